// ---- spadf_agent_end.sv ----
// Purpose : secondary agent end acting as target: decodes phases, drives read data
// Assumes : every transaction on the bus is claimed; command bit 0 low means read
// Notes   : one turnaround clock before the first data phase of every transfer
`timescale 1ns/1ps
`default_nettype none

module spadf_agent_end
  import spadf_pkg::*;
(
  input  wire logic             MCLK,
  input  wire logic             RST,
  spadf_bus_if.agt              bus,
  input  wire logic [AD_W-1:0]  RD_DATA,
  output logic                  RD_TAKE,
  output logic [63:0]           ADDR_OUT,
  output logic [CBE_W-1:0]      CMD_OUT,
  output logic                  ADDR_VALID,
  output logic [AD_W-1:0]       WR_DATA,
  output logic [CBE_W-1:0]      WR_BE_N,
  output logic                  WR_VALID,
  output logic                  PERR
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  spadf_tgt_st_t    state_r;
  logic [AD_W-1:0]  ad_o_r;
  logic             ad_oe_r;
  logic             par_o_r;
  logic             par_oe_r;
  logic             trdy_o_r;
  logic             trdy_oe_r;
  logic [63:0]      addr_r;
  logic [CBE_W-1:0] cmd_r;
  logic             avalid_r;
  logic [AD_W-1:0]  wdata_r;
  logic [CBE_W-1:0] wbe_r;
  logic             wvalid_r;
  logic             chk_r;
  logic             exp_par_r;
  logic             perr_r;

  wire done      = ~bus.sec_initiator_ready_n & ~bus.sec_target_ready_n;
  wire is_read   = ~cmd_r[SPADF_CMD_WR_BIT];
  wire addr_lo   = (state_r == SPADF_T_IDLE) & ~bus.sec_frame_n;
  wire addr_hi   = (state_r == SPADF_T_ADDR2);
  wire in_data   = (state_r == SPADF_T_DATA);
  wire wr_beat   = in_data & done & ~is_read;

  assign RD_TAKE = is_read & ((state_r == SPADF_T_WAIT) | (in_data & done & ~bus.sec_frame_n));

  // ----------------------------------------------------------------------
  // target sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_r   <= SPADF_T_IDLE;
      ad_o_r    <= SPADF_PARK_AD;
      ad_oe_r   <= 1'b0;
      trdy_o_r  <= 1'b1;
      trdy_oe_r <= 1'b0;
      addr_r    <= '0;
      cmd_r     <= SPADF_PARK_CBE;
      avalid_r  <= 1'b0;
    end else begin
      avalid_r <= 1'b0;
      unique case (state_r)
        SPADF_T_IDLE: begin
          if (addr_lo) begin
            addr_r[31:0] <= bus.sec_ad;
            cmd_r        <= bus.sec_cmd_byte_en_n;
            if (bus.sec_cmd_byte_en_n == SPADF_CMD_DUAL) begin
              state_r <= SPADF_T_ADDR2;
            end else begin
              addr_r[63:32] <= '0;
              avalid_r      <= 1'b1;
              trdy_oe_r     <= 1'b1;
              state_r       <= SPADF_T_WAIT;
            end
          end
        end
        SPADF_T_ADDR2: begin
          addr_r[63:32] <= bus.sec_ad;
          cmd_r         <= bus.sec_cmd_byte_en_n;
          avalid_r      <= 1'b1;
          trdy_oe_r     <= 1'b1;
          state_r       <= SPADF_T_WAIT;
        end
        SPADF_T_WAIT: begin
          ad_o_r   <= RD_DATA;
          ad_oe_r  <= is_read;
          trdy_o_r <= 1'b0;
          state_r  <= SPADF_T_DATA;
        end
        SPADF_T_DATA: begin
          if (done & bus.sec_frame_n) begin
            trdy_o_r <= 1'b1;
            ad_oe_r  <= 1'b0;
            state_r  <= SPADF_T_TURN;
          end else if (done) begin
            ad_o_r <= RD_DATA;
          end
        end
        SPADF_T_TURN: begin
          trdy_oe_r <= 1'b0;
          state_r   <= SPADF_T_IDLE;
        end
        default: begin
          state_r <= SPADF_T_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // parity drive and check
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      par_o_r   <= 1'b0;
      par_oe_r  <= 1'b0;
      wdata_r   <= SPADF_PARK_AD;
      wbe_r     <= SPADF_PARK_CBE;
      wvalid_r  <= 1'b0;
      chk_r     <= 1'b0;
      exp_par_r <= 1'b0;
      perr_r    <= 1'b0;
    end else begin
      par_o_r   <= spadf_even_par(ad_o_r, bus.sec_cmd_byte_en_n);
      par_oe_r  <= ad_oe_r;
      wvalid_r  <= wr_beat;
      chk_r     <= wr_beat | addr_lo | addr_hi;
      exp_par_r <= spadf_even_par(bus.sec_ad, bus.sec_cmd_byte_en_n);
      perr_r    <= chk_r & (exp_par_r != bus.sec_parity_bit);
      if (wr_beat) begin
        wdata_r <= bus.sec_ad;
        wbe_r   <= bus.sec_cmd_byte_en_n;
      end
    end
  end

  assign bus.agt_ad_o    = ad_o_r;
  assign bus.agt_ad_oe   = ad_oe_r;
  assign bus.agt_par_o   = par_o_r;
  assign bus.agt_par_oe  = par_oe_r;
  assign bus.agt_trdy_o  = trdy_o_r;
  assign bus.agt_trdy_oe = trdy_oe_r;
  assign ADDR_OUT        = addr_r;
  assign CMD_OUT         = cmd_r;
  assign ADDR_VALID      = avalid_r;
  assign WR_DATA         = wdata_r;
  assign WR_BE_N         = wbe_r;
  assign WR_VALID        = wvalid_r;
  assign PERR            = perr_r;

endmodule : spadf_agent_end

`default_nettype wire

// ---- spadf_bridge_end.sv ----
// Purpose : bridge end of the secondary bus: initiator framing, parking, parity
// Assumes : target-ready comes from the agent on MCLK; GNT_N arrives from a pin
// Notes   : no master abort, a transfer waits for target-ready without limit
`timescale 1ns/1ps
`default_nettype none

module spadf_bridge_end
  import spadf_pkg::*;
(
  input  wire logic             MCLK,
  input  wire logic             RST,
  spadf_bus_if.dev              bus,
  input  wire logic             GNT_N,
  input  wire logic             START,
  input  wire logic             WRITE,
  input  wire logic             DUAL,
  input  wire logic [CBE_W-1:0] CMD,
  input  wire logic [63:0]      ADDR,
  input  wire logic [CNT_W-1:0] COUNT,
  input  wire logic [AD_W-1:0]  WDATA,
  input  wire logic [CBE_W-1:0] BYTE_EN_N,
  output logic                  BUSY,
  output logic                  NEXT_REQ,
  output logic [AD_W-1:0]       RDATA,
  output logic                  RDATA_VALID,
  output logic                  PERR
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  spadf_dev_st_t    state_r;
  logic             gnt_meta_r;
  logic             gnt_r;
  logic [AD_W-1:0]  ad_o_r;
  logic             ad_oe_r;
  logic [CBE_W-1:0] cbe_o_r;
  logic             cbe_oe_r;
  logic             par_o_r;
  logic             par_oe_r;
  logic             frame_o_r;
  logic             frame_oe_r;
  logic             irdy_o_r;
  logic             irdy_oe_r;
  logic             write_r;
  logic             dual_r;
  logic             hi_sent_r;
  logic [CBE_W-1:0] cmd_r;
  logic [31:0]      addr_hi_r;
  logic [CNT_W-1:0] cnt_r;
  logic [AD_W-1:0]  rdata_r;
  logic             rvalid_r;
  logic             chk_r;
  logic             exp_par_r;
  logic             perr_r;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire granted    = ~gnt_r;
  wire bus_idle   = bus.sec_frame_n & bus.sec_initiator_ready_n;
  wire can_start  = (state_r == SPADF_D_IDLE) & granted & bus_idle & START;
  wire can_park   = granted & bus_idle;
  wire done       = ~bus.sec_initiator_ready_n & ~bus.sec_target_ready_n;
  wire last_beat  = (cnt_r == SPADF_CNT_ONE);
  wire enter_data = (state_r == SPADF_D_ADDR) & ~(dual_r & ~hi_sent_r);
  wire next_beat  = (state_r == SPADF_D_DATA) & done & ~last_beat;

  assign NEXT_REQ = enter_data | next_beat;
  assign BUSY     = (state_r != SPADF_D_IDLE);

  // ----------------------------------------------------------------------
  // grant synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      gnt_meta_r <= 1'b1;
      gnt_r      <= 1'b1;
    end else begin
      gnt_meta_r <= GNT_N;
      gnt_r      <= gnt_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // parity lane: always one clock behind the lines it covers
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      par_o_r  <= 1'b0;
      par_oe_r <= 1'b0;
    end else begin
      par_o_r  <= spadf_even_par(ad_o_r, cbe_o_r);
      par_oe_r <= ad_oe_r;
    end
  end

  // ----------------------------------------------------------------------
  // framing and address/data sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_r    <= SPADF_D_IDLE;
      ad_o_r     <= SPADF_PARK_AD;
      ad_oe_r    <= 1'b0;
      cbe_o_r    <= SPADF_PARK_CBE;
      cbe_oe_r   <= 1'b0;
      frame_o_r  <= 1'b1;
      frame_oe_r <= 1'b0;
      irdy_o_r   <= 1'b1;
      irdy_oe_r  <= 1'b0;
      write_r    <= 1'b0;
      dual_r     <= 1'b0;
      hi_sent_r  <= 1'b0;
      cmd_r      <= SPADF_PARK_CBE;
      addr_hi_r  <= SPADF_PARK_AD;
      cnt_r      <= SPADF_CNT_ONE;
    end else begin
      unique case (state_r)
        SPADF_D_IDLE: begin
          frame_oe_r <= 1'b0;
          irdy_oe_r  <= 1'b0;
          if (can_start) begin
            write_r    <= WRITE;
            dual_r     <= DUAL;
            hi_sent_r  <= 1'b0;
            cmd_r      <= CMD;
            addr_hi_r  <= ADDR[63:32];
            cnt_r      <= (COUNT == '0) ? SPADF_CNT_ONE : COUNT;
            ad_o_r     <= ADDR[31:0];
            ad_oe_r    <= 1'b1;
            cbe_o_r    <= DUAL ? SPADF_CMD_DUAL : CMD;
            cbe_oe_r   <= 1'b1;
            frame_o_r  <= 1'b0;
            frame_oe_r <= 1'b1;
            irdy_o_r   <= 1'b1;
            irdy_oe_r  <= 1'b1;
            state_r    <= SPADF_D_ADDR;
          end else if (can_park) begin
            ad_o_r   <= SPADF_PARK_AD;
            ad_oe_r  <= 1'b1;
            cbe_o_r  <= SPADF_PARK_CBE;
            cbe_oe_r <= 1'b1;
          end else begin
            ad_oe_r  <= 1'b0;
            cbe_oe_r <= 1'b0;
          end
        end
        SPADF_D_ADDR: begin
          if (dual_r & ~hi_sent_r) begin
            hi_sent_r <= 1'b1;
            ad_o_r    <= addr_hi_r;
            cbe_o_r   <= cmd_r;
          end else begin
            // reads turn the lines round so the target can drive them
            ad_o_r    <= WDATA;
            ad_oe_r   <= write_r;
            cbe_o_r   <= BYTE_EN_N;
            irdy_o_r  <= 1'b0;
            frame_o_r <= last_beat;
            state_r   <= SPADF_D_DATA;
          end
        end
        SPADF_D_DATA: begin
          if (done & last_beat) begin
            frame_o_r <= 1'b1;
            irdy_o_r  <= 1'b1;
            ad_oe_r   <= 1'b0;
            cbe_oe_r  <= 1'b0;
            state_r   <= SPADF_D_TURN;
          end else if (done) begin
            cnt_r     <= cnt_r - SPADF_CNT_ONE;
            ad_o_r    <= WDATA;
            cbe_o_r   <= BYTE_EN_N;
            frame_o_r <= (cnt_r == SPADF_CNT_TWO);
          end
        end
        SPADF_D_TURN: begin
          frame_oe_r <= 1'b0;
          irdy_oe_r  <= 1'b0;
          state_r    <= SPADF_D_IDLE;
        end
        default: begin
          state_r <= SPADF_D_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // read capture and received parity check
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_r   <= SPADF_PARK_AD;
      rvalid_r  <= 1'b0;
      chk_r     <= 1'b0;
      exp_par_r <= 1'b0;
      perr_r    <= 1'b0;
    end else begin
      rvalid_r  <= (state_r == SPADF_D_DATA) & done & ~write_r;
      chk_r     <= (state_r == SPADF_D_DATA) & done & ~write_r;
      exp_par_r <= spadf_even_par(bus.sec_ad, bus.sec_cmd_byte_en_n);
      perr_r    <= chk_r & (exp_par_r != bus.sec_parity_bit);
      if ((state_r == SPADF_D_DATA) & done & ~write_r) begin
        rdata_r <= bus.sec_ad;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign bus.dev_ad_o     = ad_o_r;
  assign bus.dev_ad_oe    = ad_oe_r;
  assign bus.dev_cbe_o    = cbe_o_r;
  assign bus.dev_cbe_oe   = cbe_oe_r;
  assign bus.dev_par_o    = par_o_r;
  assign bus.dev_par_oe   = par_oe_r;
  assign bus.dev_frame_o  = frame_o_r;
  assign bus.dev_frame_oe = frame_oe_r;
  assign bus.dev_irdy_o   = irdy_o_r;
  assign bus.dev_irdy_oe  = irdy_oe_r;
  assign RDATA            = rdata_r;
  assign RDATA_VALID      = rvalid_r;
  assign PERR             = perr_r;

endmodule : spadf_bridge_end

`default_nettype wire

// ---- spadf_bus_asserts.sv ----
// Purpose : concurrent checks on the shared secondary bus lines
// Assumes : single clock MCLK, synchronous active-high RST
// Notes   : per-end enables are watched, so contention shows up directly
`timescale 1ns/1ps
`default_nettype none

module spadf_bus_asserts
  import spadf_pkg::*;
(
  input wire logic             MCLK,
  input wire logic             RST,
  input wire logic             dev_ad_oe,
  input wire logic             dev_cbe_oe,
  input wire logic             dev_par_oe,
  input wire logic             dev_frame_o,
  input wire logic             dev_frame_oe,
  input wire logic             agt_ad_oe,
  input wire logic             agt_par_oe,
  input wire logic             agt_trdy_o,
  input wire logic             agt_trdy_oe,
  input wire logic [AD_W-1:0]  sec_ad,
  input wire logic [CBE_W-1:0] sec_cmd_byte_en_n,
  input wire logic             sec_parity_bit,
  input wire logic             sec_frame_n,
  input wire logic             sec_initiator_ready_n,
  input wire logic             sec_target_ready_n
);
  logic last_xfer;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  assign last_xfer = sec_frame_n && !sec_initiator_ready_n && !sec_target_ready_n;

  chk_par_owner: assert property (
    dev_par_oe == $past(dev_ad_oe) && agt_par_oe == $past(agt_ad_oe))
    else $error("parity enable not one clock behind address/data enable");
  chk_par_even: assert property (
    (dev_par_oe || agt_par_oe) |-> sec_parity_bit == ^{$past(sec_ad), $past(sec_cmd_byte_en_n)})
    else $error("parity bit is not even parity of the previous clock");
  chk_no_clash: assert property (
    !(dev_ad_oe && agt_ad_oe) && !(dev_par_oe && agt_par_oe))
    else $error("both ends drive the address/data or parity lines");
  chk_data_owner: assert property (
    (!sec_initiator_ready_n && !sec_target_ready_n) |-> dev_ad_oe != agt_ad_oe)
    else $error("no single data driver during a transfer");
  chk_addr_cmd: assert property (
    $fell(sec_frame_n) |-> dev_ad_oe && dev_cbe_oe)
    else $error("address phase without address and command driven");
  chk_dual_second: assert property (
    $fell(sec_frame_n) && sec_cmd_byte_en_n == SPADF_CMD_DUAL
      |=> dev_cbe_oe && sec_cmd_byte_en_n != SPADF_CMD_DUAL && sec_initiator_ready_n)
    else $error("dual address not followed by a second address phase");
  chk_byte_en: assert property (
    !sec_initiator_ready_n |-> dev_cbe_oe)
    else $error("byte enables not driven in a data phase");
  chk_frame_hold: assert property (
    !sec_frame_n && !sec_initiator_ready_n && sec_target_ready_n |=> $stable(sec_frame_n))
    else $error("frame changed while a data phase was waiting");
  chk_frame_last: assert property (
    $rose(sec_frame_n) |-> !sec_initiator_ready_n)
    else $error("frame deasserted outside a data phase");
  chk_frame_idle: assert property (
    last_xfer |=> dev_frame_oe && dev_frame_o ##1 !dev_frame_oe)
    else $error("frame not driven high for one clock then released");
  chk_trdy_idle: assert property (
    last_xfer |=> agt_trdy_oe && agt_trdy_o ##1 !agt_trdy_oe)
    else $error("target ready not driven high for one clock then released");

  cov_dual: cover property ($fell(sec_frame_n) && sec_cmd_byte_en_n == SPADF_CMD_DUAL);
  cov_read: cover property (last_xfer && agt_ad_oe);
  cov_park: cover property ($rose(dev_ad_oe) && sec_frame_n);

endmodule : spadf_bus_asserts

`default_nettype wire

// ---- spadf_bus_if.sv ----
// Purpose : carrier joining the bridge end and the secondary agent end
// Assumes : each end drives an output value and an enable per line it owns; the agent owns only address/data, parity and target-ready
// Notes   : undriven framing lines read high (pull-ups), undriven data lines read as float level
`timescale 1ns/1ps
`default_nettype none

interface spadf_bus_if;
  import spadf_pkg::*;

  // bridge end drivers
  logic [AD_W-1:0]  dev_ad_o;
  logic             dev_ad_oe;
  logic [CBE_W-1:0] dev_cbe_o;
  logic             dev_cbe_oe;
  logic             dev_par_o;
  logic             dev_par_oe;
  logic             dev_frame_o;
  logic             dev_frame_oe;
  logic             dev_irdy_o;
  logic             dev_irdy_oe;
  // agent end drivers
  logic [AD_W-1:0]  agt_ad_o;
  logic             agt_ad_oe;
  logic             agt_par_o;
  logic             agt_par_oe;
  logic             agt_trdy_o;
  logic             agt_trdy_oe;
  // resolved bus
  logic [AD_W-1:0]  sec_ad;
  logic [CBE_W-1:0] sec_cmd_byte_en_n;
  logic             sec_parity_bit;
  logic             sec_frame_n;
  logic             sec_initiator_ready_n;
  logic             sec_target_ready_n;

  // ----------------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------------
  assign sec_ad = dev_ad_oe ? dev_ad_o : (agt_ad_oe ? agt_ad_o : SPADF_FLOAT_AD);
  assign sec_cmd_byte_en_n = dev_cbe_oe ? dev_cbe_o : SPADF_FLOAT_CBE;
  assign sec_parity_bit = dev_par_oe ? dev_par_o : (agt_par_oe ? agt_par_o : 1'b0);
  assign sec_frame_n = dev_frame_oe ? dev_frame_o : 1'b1;
  assign sec_initiator_ready_n = dev_irdy_oe ? dev_irdy_o : 1'b1;
  assign sec_target_ready_n = agt_trdy_oe ? agt_trdy_o : 1'b1;

  modport dev (
    output dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe, dev_par_o, dev_par_oe,
    output dev_frame_o, dev_frame_oe, dev_irdy_o, dev_irdy_oe,
    input  sec_ad, sec_cmd_byte_en_n, sec_parity_bit, sec_frame_n,
    input  sec_initiator_ready_n, sec_target_ready_n
  );

  modport agt (
    output agt_ad_o, agt_ad_oe, agt_par_o, agt_par_oe, agt_trdy_o, agt_trdy_oe,
    input  sec_ad, sec_cmd_byte_en_n, sec_parity_bit, sec_frame_n,
    input  sec_initiator_ready_n, sec_target_ready_n
  );

endinterface : spadf_bus_if

`default_nettype wire

// ---- spadf_pkg.sv ----
// Purpose : shared constants, types and parity helper for the secondary bus framing ends
// Assumes : one clock (MCLK, 200 MHz), synchronous active-high reset
// Notes   : bus levels are resolved in the carrier interface, never in the ends

// ----------------------------------------------------------------------
// package
// ----------------------------------------------------------------------
package spadf_pkg;

  localparam int AD_W  = 32;
  localparam int CBE_W = 4;
  localparam int CNT_W = 8;

  // commands seen on the command/byte-enable lines in address phases
  localparam logic [CBE_W-1:0] SPADF_CMD_MEM_RD = 4'h6;
  localparam logic [CBE_W-1:0] SPADF_CMD_MEM_WR = 4'h7;
  localparam logic [CBE_W-1:0] SPADF_CMD_DUAL   = 4'hd;
  // command bit that tells a write from a read
  localparam int               SPADF_CMD_WR_BIT = 0;

  // values parked on the idle bus; any valid level will do
  localparam logic [AD_W-1:0]  SPADF_PARK_AD  = 32'h0000_0000;
  localparam logic [CBE_W-1:0] SPADF_PARK_CBE = 4'h0;

  // level seen on the address/data and command/byte-enable lines when nobody drives them
  localparam logic [AD_W-1:0]  SPADF_FLOAT_AD  = 32'h0000_0000;
  localparam logic [CBE_W-1:0] SPADF_FLOAT_CBE = 4'h0;

  localparam logic [CNT_W-1:0] SPADF_CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] SPADF_CNT_TWO = 8'h02;

  typedef enum logic [2:0] {
    SPADF_D_IDLE,
    SPADF_D_ADDR,
    SPADF_D_DATA,
    SPADF_D_TURN
  } spadf_dev_st_t;

  typedef enum logic [2:0] {
    SPADF_T_IDLE,
    SPADF_T_ADDR2,
    SPADF_T_WAIT,
    SPADF_T_DATA,
    SPADF_T_TURN
  } spadf_tgt_st_t;

  // even parity over the 36 shared bits
  function automatic logic spadf_even_par(input logic [AD_W-1:0]  ad,
                                          input logic [CBE_W-1:0] cbe_n);
    return ^{ad, cbe_n};
  endfunction : spadf_even_par

endpackage : spadf_pkg

// ---- tb_secondary_pci_addr_data_framing.sv ----
// Purpose : self-checking bench joining the bridge end and the agent end
// Assumes : 200 MHz clock; inputs change 1 ns after the rising edge
// Notes   : a second carrier lets the bench play a faulty agent
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_secondary_pci_addr_data_framing
  import spadf_pkg::*;
;
  logic             MCLK, RST, GNT_N, START, START2, WRITE, DUAL;
  logic [CBE_W-1:0] CMD, BYTE_EN_N, CMD_OUT, WR_BE_N, p_cbe;
  logic [63:0]      ADDR, ADDR_OUT;
  logic [CNT_W-1:0] COUNT;
  logic [AD_W-1:0]  WDATA, RD_DATA, RDATA, WR_DATA, p_ad;
  logic             BUSY, NEXT_REQ, RDATA_VALID, PERR_B, PERR_2, par_bad, p_frame_n;
  logic             RD_TAKE, ADDR_VALID, WR_VALID, PERR_A;
  int               n_mismatch, checks_done, beat, rbeat, wr_n, rv_n, cycles, k;

  function automatic logic [AD_W-1:0] wd(input int i);
    return {16'ha5c3, i[15:0]};
  endfunction : wd

  function automatic logic [AD_W-1:0] rdv(input int i);
    return ~wd(i);
  endfunction : rdv

  spadf_bus_if bus ();
  spadf_bus_if bus2 ();

  spadf_bridge_end spadf_bridge_end_i (.MCLK(MCLK), .RST(RST), .bus(bus), .GNT_N(GNT_N),
    .START(START), .WRITE(WRITE), .DUAL(DUAL), .CMD(CMD), .ADDR(ADDR), .COUNT(COUNT),
    .WDATA(WDATA), .BYTE_EN_N(BYTE_EN_N), .BUSY(BUSY), .NEXT_REQ(NEXT_REQ), .RDATA(RDATA),
    .RDATA_VALID(RDATA_VALID), .PERR(PERR_B));
  // second bridge faces the bench itself, which breaks read parity on purpose
  spadf_bridge_end spadf_bridge_end_bad_i (.MCLK(MCLK), .RST(RST), .bus(bus2), .GNT_N(GNT_N),
    .START(START2), .WRITE(WRITE), .DUAL(DUAL), .CMD(CMD), .ADDR(ADDR), .COUNT(COUNT),
    .WDATA(WDATA), .BYTE_EN_N(BYTE_EN_N), .BUSY(), .NEXT_REQ(), .RDATA(),
    .RDATA_VALID(), .PERR(PERR_2));
  spadf_agent_end spadf_agent_end_i (.MCLK(MCLK), .RST(RST), .bus(bus), .RD_DATA(RD_DATA),
    .RD_TAKE(RD_TAKE), .ADDR_OUT(ADDR_OUT), .CMD_OUT(CMD_OUT), .ADDR_VALID(ADDR_VALID),
    .WR_DATA(WR_DATA), .WR_BE_N(WR_BE_N), .WR_VALID(WR_VALID), .PERR(PERR_A));
  spadf_bus_asserts spadf_bus_asserts_i (.MCLK(MCLK), .RST(RST), .dev_ad_oe(bus.dev_ad_oe),
    .dev_cbe_oe(bus.dev_cbe_oe), .dev_par_oe(bus.dev_par_oe), .dev_frame_o(bus.dev_frame_o),
    .dev_frame_oe(bus.dev_frame_oe), .agt_ad_oe(bus.agt_ad_oe), .agt_par_oe(bus.agt_par_oe),
    .agt_trdy_o(bus.agt_trdy_o), .agt_trdy_oe(bus.agt_trdy_oe), .sec_ad(bus.sec_ad),
    .sec_cmd_byte_en_n(bus.sec_cmd_byte_en_n), .sec_parity_bit(bus.sec_parity_bit),
    .sec_frame_n(bus.sec_frame_n), .sec_initiator_ready_n(bus.sec_initiator_ready_n),
    .sec_target_ready_n(bus.sec_target_ready_n));

  // ----------------------------------------------------------------------
  // clock, beat feeds, monitor
  // ----------------------------------------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    if (NEXT_REQ === 1'b1) begin
      #1;
      beat++;
      WDATA = wd(beat);
      BYTE_EN_N = beat[3:0];
    end
  end

  always @(posedge MCLK) begin
    if (RD_TAKE === 1'b1) begin
      #1;
      rbeat++;
      RD_DATA = rdv(rbeat);
    end
  end

  always @(posedge MCLK) begin
    if (RST === 1'b0) begin
      `CHK({PERR_B, PERR_A}, 2'b00)
      if (p_frame_n === 1'b1 && bus.sec_frame_n === 1'b0) begin
        `CHK(bus.sec_ad, ADDR[31:0])
        `CHK(bus.sec_cmd_byte_en_n, DUAL ? SPADF_CMD_DUAL : CMD)
      end
      if (bus.dev_par_oe === 1'b1 || bus.agt_par_oe === 1'b1)
        `CHK(bus.sec_parity_bit, ^{p_ad, p_cbe})
      if (ADDR_VALID === 1'b1) begin
        `CHK({CMD_OUT, ADDR_OUT[31:0]}, {CMD, ADDR[31:0]})
        `CHK(ADDR_OUT[63:32], DUAL ? ADDR[63:32] : 32'h0)
      end
      if (WR_VALID === 1'b1) begin
        `CHK({WR_BE_N, WR_DATA}, {wr_n[3:0], wd(wr_n)})
        wr_n++;
      end
      if (RDATA_VALID === 1'b1) begin
        `CHK(RDATA, rdv(rv_n))
        rv_n++;
      end
    end
    p_ad = bus.sec_ad;
    p_cbe = bus.sec_cmd_byte_en_n;
    p_frame_n = bus.sec_frame_n;
  end

  // a stuck handshake would otherwise hang the run
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic xfer(input logic w, input logic d, input logic [CBE_W-1:0] c,
                      input logic [63:0] a, input logic [CNT_W-1:0] n);
    int t;
    WRITE = w;
    DUAL = d;
    CMD = c;
    ADDR = a;
    COUNT = n;
    beat = 0;
    rbeat = 0;
    wr_n = 0;
    rv_n = 0;
    WDATA = wd(0);
    BYTE_EN_N = 4'h0;
    RD_DATA = rdv(0);
    START = 1'b1;
    t = 0;
    while (BUSY !== 1'b1 && t < 50) begin
      @(posedge MCLK);
      #1 t++;
    end
    START = 1'b0;
    while (BUSY !== 1'b0 && t < 300) begin
      @(posedge MCLK);
      #1 t++;
    end
    `CHK(w ? wr_n : rv_n, (n == 8'h00) ? 1 : int'(n))
  endtask : xfer

  task final_report();
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {RST, GNT_N, START, START2, WRITE, DUAL, p_frame_n} = 7'h61;
    {CMD, ADDR, COUNT, WDATA, BYTE_EN_N, RD_DATA, p_ad, p_cbe} = '0;
    {n_mismatch, checks_done, beat, rbeat, wr_n, rv_n, cycles} = '0;
    {bus2.agt_ad_o, bus2.agt_ad_oe, bus2.agt_par_o, bus2.agt_par_oe} = '0;
    {bus2.agt_trdy_o, bus2.agt_trdy_oe} = 2'h2;
    repeat (10) @(posedge MCLK);
    #1 RST = 1'b0;
    START = 1'b1;
    repeat (8) @(posedge MCLK);
    #1 `CHK({BUSY, bus.sec_frame_n}, 2'b01)
    START = 1'b0;
    GNT_N = 1'b0;
    repeat (6) @(posedge MCLK);
    #1 `CHK({bus.dev_ad_oe, bus.sec_ad}, {1'b1, SPADF_PARK_AD})
    `CHK({bus.dev_cbe_oe, bus.sec_cmd_byte_en_n}, {1'b1, SPADF_PARK_CBE})
    `CHK(bus.dev_par_oe, 1'b1)
    `CHK(bus.sec_parity_bit, ^{SPADF_PARK_AD, SPADF_PARK_CBE})
    xfer(1'b1, 1'b0, SPADF_CMD_MEM_WR, 64'h0000_0000_1000_0040, 8'h01);
    xfer(1'b0, 1'b0, SPADF_CMD_MEM_RD, 64'h0000_0000_2000_0100, 8'h04);
    xfer(1'b1, 1'b1, SPADF_CMD_MEM_WR, 64'h0000_0001_3000_0200, 8'h03);
    xfer(1'b0, 1'b1, SPADF_CMD_MEM_RD, 64'h0000_00ff_4000_0300, 8'h00);
    xfer(1'b1, 1'b0, SPADF_CMD_MEM_WR, 64'h0000_0000_ffff_fffc, 8'h08);
    WRITE = 1'b0;
    DUAL = 1'b0;
    CMD = SPADF_CMD_MEM_RD;
    COUNT = 8'h01;
    START2 = 1'b1;
    k = 0;
    while (bus2.sec_frame_n !== 1'b0 && k < 20) begin
      @(posedge MCLK);
      #1 k++;
    end
    START2 = 1'b0;
    @(posedge MCLK);
    #1 {bus2.agt_trdy_oe, bus2.agt_trdy_o} = 2'h3;
    @(posedge MCLK);
    #1 {bus2.agt_ad_oe, bus2.agt_ad_o, bus2.agt_trdy_o} = {1'b1, 32'h1234_5678, 1'b0};
    par_bad = ~^{32'h1234_5678, bus2.sec_cmd_byte_en_n};
    @(posedge MCLK);
    #1 {bus2.agt_ad_oe, bus2.agt_par_oe, bus2.agt_par_o, bus2.agt_trdy_o} = {2'h1, par_bad, 1'b1};
    @(posedge MCLK);
    #1 {bus2.agt_par_oe, bus2.agt_trdy_oe} = 2'h0;
    k = 0;
    while (PERR_2 !== 1'b1 && k < 8) begin
      @(posedge MCLK);
      #1 k++;
    end
    `CHK(PERR_2, 1'b1)
    final_report();
  end

endmodule : tb_secondary_pci_addr_data_framing

`undef CHK
`default_nettype wire
